// ### vst_pkg.sv
// Shared constants, state type and helper functions for the display scan timing block
package vst_pkg;

	// Register addresses
	localparam logic [15:0] ADDR_MODE_A   = 16'hffa0;
	localparam logic [15:0] ADDR_SCAN     = 16'hffa1;
	localparam logic [15:0] ADDR_MASK     = 16'hffa2;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hffa3;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hffa4;

	// Values after reset
	localparam logic [7:0] RST_MODE_A   = 8'h00;
	localparam logic [7:0] RST_SCAN     = 8'h00;
	localparam logic [7:0] RST_MASK     = 8'h00;
	localparam logic [1:0] RST_IRQ      = 2'h0;

	// Field positions in display_mode_reg_a
	localparam int MODE_A_KSF_BIT    = 7;
	localparam int MODE_A_LAYOUT_BIT = 5;
	localparam int MODE_A_SEG_LSB    = 0;
	localparam logic [7:0] MODE_A_WR_MASK = 8'h7f;

	// Field positions in scan_timing_reg
	localparam int SCAN_CYC_BIT = 0;
	localparam int SCAN_CUT_LSB = 1;
	localparam int SCAN_DIG_LSB = 4;

	// Mask count holds six bits, upper two read zero
	localparam logic [7:0] MASK_WR_MASK = 8'h3f;

	// Interrupt status bits
	localparam int IRQ_KS_BIT    = 0;
	localparam int IRQ_FRAME_BIT = 1;

	// Display cycle lengths in main clock periods
	localparam logic [11:0] CYC_SHORT = 12'h400;
	localparam logic [11:0] CYC_LONG  = 12'h800;
	localparam logic [10:0] CYC_LAST_SHORT = 11'(CYC_SHORT - 12'h001);
	localparam logic [10:0] CYC_LAST_LONG  = 11'(CYC_LONG - 12'h001);

	// Pin budget
	localparam int PIN_COUNT     = 53;
	localparam int SEG_IN_W      = 40;
	localparam int KS_PORT_FIRST = 13;
	localparam logic [5:0] PIN_TOTAL = 6'h35;
	localparam logic [5:0] SEG_BASE  = 6'h09;

	// Scan sequencer states, Gray along stop, blank, display, key scan
	typedef enum logic [1:0] {
		ST_STOP    = 2'b00,
		ST_BLANK   = 2'b01,
		ST_DISP    = 2'b11,
		ST_KEYSCAN = 2'b10
	} vst_state_t;

	// Last count of a display cycle
	function automatic logic [10:0] vst_cycle_last(input logic len_sel);
		return len_sel ? CYC_LAST_LONG : CYC_LAST_SHORT;
	endfunction : vst_cycle_last

	// Half the cut width in clocks: sixteenths 1,2,4..14 of the cycle, split over both ends
	function automatic logic [10:0] vst_cut_half(input logic len_sel, input logic [2:0] sel);
		logic [3:0] num;
		num = (sel == 3'h0) ? 4'h1 : {sel, 1'b0}; // RULE_01
		return len_sel ? {1'b0, num, 6'h00} : {2'b00, num, 5'h00};
	endfunction : vst_cut_half

endpackage : vst_pkg

// ### vst_cycle_timer.sv
// Display cycle counter and cut window generator
`timescale 1ns/1ps
module vst_cycle_timer
	import vst_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_restart,
	input  wire logic       i_len_sel,
	input  wire logic [2:0] i_cut_sel,
	output logic            o_cycle_end,
	output logic            o_window
);
	import vst_pkg::*;

	logic [10:0] cnt_reg;
	logic [10:0] cnt_next;
	logic [10:0] last;
	logic [10:0] half;

	// Cut bounds follow the live settings, so a change takes effect mid cycle
	always_comb begin
		last        = vst_cycle_last(i_len_sel);
		half        = vst_cut_half(i_len_sel, i_cut_sel);
		o_cycle_end = (cnt_reg >= last) && !i_restart; // RULE_10
		o_window    = (cnt_reg >= half) && (cnt_reg <= 11'(last - half)); // RULE_02
		if (i_restart || o_cycle_end) begin
			cnt_next = 11'h000;
		end else begin
			cnt_next = 11'(cnt_reg + 11'h001);
		end
	end

	// Counter register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			cnt_reg <= 11'h000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	a_cut_rise_point: assert property ($rose(o_window) && $stable(i_cut_sel) && $stable(i_len_sel)
		|-> cnt_reg == vst_cut_half(i_len_sel, i_cut_sel)) // RULE_01
		else $error("window opened at wrong count");
	a_cut_both_ends: assert property (cnt_reg == 11'h000 || cnt_reg == last |-> !o_window) // RULE_02
		else $error("window open at cycle edge");
	a_cycle_wrap: assert property (cnt_reg == CYC_LAST_SHORT && !i_len_sel && !i_restart
		|-> o_cycle_end ##1 cnt_reg == 11'h000) // RULE_15
		else $error("short cycle did not end at 1024 clocks");
	a_long_cycle: assert property (cnt_reg == CYC_LAST_SHORT && i_len_sel |-> !o_cycle_end) // RULE_15
		else $error("long cycle ended early");

endmodule : vst_cycle_timer

// ### vst_pin_mux.sv
// Assigns the 53 output pins to digits, segments and port latches
`timescale 1ns/1ps
module vst_pin_mux
	import vst_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst_b,
	input  wire logic                 i_stopped,
	input  wire logic                 i_drive,
	input  wire logic                 i_keyscan,
	input  wire logic                 i_window,
	input  wire logic                 i_layout,
	input  wire logic [3:0]           i_digit_code,
	input  wire logic [4:0]           i_seg_code,
	input  wire logic [3:0]           i_digit_index,
	input  wire logic [SEG_IN_W-1:0]  i_seg_data,
	input  wire logic [PIN_COUNT-1:0] i_port_latch,
	output logic [PIN_COUNT-1:0]      o_pin
);
	import vst_pkg::*;

	logic [PIN_COUNT-1:0] pin_next;
	logic [5:0]           digits;
	logic [5:0]           outs;
	logic [5:0]           segs;

	// Digits claim their pins first; segments shrink to what is left
	always_comb begin
		digits = {1'b0, i_digit_code} + 6'h01;
		outs   = {1'b0, i_seg_code} + SEG_BASE;
		if (i_layout) begin
			segs = (outs > digits) ? 6'(outs - digits) : 6'h00; // RULE_16
		end else begin
			segs = outs;
		end
		if (6'(digits + segs) > PIN_TOTAL) begin
			segs = 6'(PIN_TOTAL - digits); // RULE_13
		end
		for (int p = 0; p < PIN_COUNT; p++) begin
			if (i_stopped) begin
				pin_next[p] = i_port_latch[p];
			end else if (i_keyscan && p >= KS_PORT_FIRST) begin
				pin_next[p] = i_port_latch[p]; // RULE_18
			end else if (i_keyscan) begin
				pin_next[p] = 1'b0; // RULE_18
			end else if (p < int'(digits)) begin
				pin_next[p] = i_drive && i_window && (p == int'(i_digit_index)); // RULE_02
			end else if (p < int'(digits) + int'(segs)) begin
				pin_next[p] = i_drive && i_window && i_seg_data[p - int'(digits)]; // RULE_03
			end else begin
				pin_next[p] = i_port_latch[p];
			end
		end
	end

	// Pins leave from flops so the panel sees no decode glitches
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			o_pin <= '0;
		end else begin
			o_pin <= pin_next;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	a_pin_budget: assert property (!i_stopped |-> 6'(digits + segs) <= PIN_TOTAL) // RULE_13
		else $error("digits plus segments exceed pin budget");

endmodule : vst_pin_mux

// ### vst_scan_ctrl.sv
// Display scan timing controller: registers, scan sequencer, interrupt, pin drive
// Notes on behaviour
// RULE_01 - Cut field picks 1/16 to 14/16
// RULE_02 - Digit pulse trimmed equally at both ends
// RULE_03 - Segments trimmed by the same cut
// RULE_04 - Digit count zero stops; else 2..16 digits
// RULE_05 - Layout two counts patterns the same way
// RULE_06 - Stopped: software drives pins via port latches
// RULE_07 - Mask count 0..39; above 39 forbidden
// RULE_08 - Mask count resets zero, upper bits zero
// RULE_09 - First cycle after start outputs zero
// RULE_10 - Display cycle is 1024 or 2048 clocks
// RULE_11 - Key scan slot lasts one display cycle
// RULE_12 - Eight pulse widths from cut field
// RULE_13 - Digits win when pins exceed 53
// RULE_14 - Layout select is bit 5, register A
// RULE_15 - Cycle bit: 0 short, 1 long
// RULE_16 - Layout bit: 0 character, 1 spanning segments
// RULE_17 - Key scan flag reads one only in slot
// RULE_18 - Key scan: drive low, ports on shared pins
// RULE_19 - Digits ascend, then key scan, repeat
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module vst_scan_ctrl
	import vst_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst_b,
	input  wire logic [15:0]          i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic [7:0]                o_rdata,
	input  wire logic [SEG_IN_W-1:0]  i_seg_data,
	input  wire logic [PIN_COUNT-1:0] i_port_latch,
	output logic [PIN_COUNT-1:0]      o_pin,
	output logic [3:0]                o_digit_index,
	output logic                      o_irq
);
	import vst_pkg::*;

	vst_state_t  state_reg;
	vst_state_t  state_next;
	logic [3:0]  idx_reg;
	logic [3:0]  idx_next;
	logic [7:0]  mode_a_reg;
	logic [7:0]  mode_a_next;
	logic [7:0]  scan_timing_reg;
	logic [7:0]  scan_timing_next;
	logic [7:0]  mask_count_reg;
	logic [7:0]  mask_count_next;
	logic [1:0]  irq_stat_reg;
	logic [1:0]  irq_stat_next;
	logic [1:0]  irq_mask_reg;
	logic [1:0]  irq_mask_next;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic        irq_reg;
	logic        irq_next;
	logic [1:0]  irq_set;
	logic        cycle_end;
	logic        window;
	logic [3:0]  digit_code;
	logic        keyscan_flag;
	logic        layout_mode_sel;
	logic        cycle_length_sel;
	logic [2:0]  cut_width_sel;

	// Field views of the mode registers
	always_comb begin
		digit_code       = scan_timing_reg[SCAN_DIG_LSB +: 4];
		cut_width_sel    = scan_timing_reg[SCAN_CUT_LSB +: 3]; // RULE_12
		cycle_length_sel = scan_timing_reg[SCAN_CYC_BIT];
		layout_mode_sel  = mode_a_reg[MODE_A_LAYOUT_BIT]; // RULE_14
		keyscan_flag     = (state_reg == ST_KEYSCAN); // RULE_17
	end

	// Cycle counter held at zero while stopped so a start begins a fresh cycle
	vst_cycle_timer u_timer (
		.i_core_clk  (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_restart   (state_reg == ST_STOP),
		.i_len_sel   (cycle_length_sel),
		.i_cut_sel   (cut_width_sel),
		.o_cycle_end (cycle_end),
		.o_window    (window)
	);

	// Pin assignment; blank cycle and key scan leave drive off
	vst_pin_mux u_mux (
		.i_core_clk    (i_core_clk),
		.i_rst_b       (i_rst_b),
		.i_stopped     (state_reg == ST_STOP),
		.i_drive       (state_reg == ST_DISP),
		.i_keyscan     (keyscan_flag),
		.i_window      (window),
		.i_layout      (layout_mode_sel),
		.i_digit_code  (digit_code),
		.i_seg_code    (mode_a_reg[MODE_A_SEG_LSB +: 5]),
		.i_digit_index (idx_reg),
		.i_seg_data    (i_seg_data),
		.i_port_latch  (i_port_latch),
		.o_pin         (o_pin)
	);

	// Scan sequencer: blank cycle, digits in ascending order, then key scan
	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		irq_set    = 2'h0;
		unique case (state_reg)
			ST_STOP: begin
				idx_next = 4'h0;
				if (digit_code != 4'h0) begin
					state_next = ST_BLANK; // RULE_09
				end
			end
			ST_BLANK: begin
				if (cycle_end) begin
					state_next             = ST_DISP;
					idx_next               = 4'h0;
					irq_set[IRQ_FRAME_BIT] = 1'b1;
				end
			end
			ST_DISP: begin
				if (cycle_end) begin
					if (idx_reg >= digit_code) begin
						state_next          = ST_KEYSCAN; // RULE_19
						irq_set[IRQ_KS_BIT] = 1'b1;
					end else begin
						idx_next = 4'(idx_reg + 4'h1); // RULE_19
					end
				end
			end
			ST_KEYSCAN: begin
				if (cycle_end) begin
					state_next             = ST_DISP; // RULE_11
					idx_next               = 4'h0;
					irq_set[IRQ_FRAME_BIT] = 1'b1;
				end
			end
		endcase
		// Same count field for digits or patterns; zero halts in both layouts
		if (digit_code == 4'h0) begin
			state_next = ST_STOP; // RULE_04 RULE_05 RULE_06
			idx_next   = 4'h0;
		end
	end

	// Sequencer registers
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			state_reg <= ST_STOP;
			idx_reg   <= 4'h0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
		end
	end

	// Register writes, read mux and interrupt; event set wins over a clearing write
	always_comb begin
		mode_a_next      = mode_a_reg;
		scan_timing_next = scan_timing_reg;
		mask_count_next  = mask_count_reg;
		irq_mask_next    = irq_mask_reg;
		irq_stat_next    = irq_stat_reg;
		rdata_next       = 8'h00;
		if (i_wr) begin
			unique case (i_addr)
				ADDR_MODE_A:   mode_a_next = i_wdata & MODE_A_WR_MASK; // RULE_17
				ADDR_SCAN:     scan_timing_next = i_wdata;
				ADDR_MASK:     mask_count_next = i_wdata & MASK_WR_MASK; // RULE_07 RULE_08
				ADDR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~i_wdata[1:0];
				ADDR_IRQ_MASK: irq_mask_next = i_wdata[1:0];
				default:       mode_a_next = mode_a_reg;
			endcase
		end
		irq_stat_next = irq_stat_next | irq_set;
		if (i_rd) begin
			unique case (i_addr)
				ADDR_MODE_A:   rdata_next = {keyscan_flag, mode_a_reg[6:0]}; // RULE_17
				ADDR_SCAN:     rdata_next = scan_timing_reg;
				ADDR_MASK:     rdata_next = mask_count_reg;
				ADDR_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
				ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
				default:       rdata_next = 8'h00;
			endcase
		end
		irq_next = |(irq_stat_reg & irq_mask_reg);
	end

	// Register file flops
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			mode_a_reg      <= RST_MODE_A;
			scan_timing_reg <= RST_SCAN;
			mask_count_reg  <= RST_MASK; // RULE_08
			irq_stat_reg    <= RST_IRQ;
			irq_mask_reg    <= RST_IRQ;
			rdata_reg       <= 8'h00;
			irq_reg         <= 1'b0;
		end else begin
			mode_a_reg      <= mode_a_next;
			scan_timing_reg <= scan_timing_next;
			mask_count_reg  <= mask_count_next;
			irq_stat_reg    <= irq_stat_next;
			irq_mask_reg    <= irq_mask_next;
			rdata_reg       <= rdata_next;
			irq_reg         <= irq_next;
		end
	end

	assign o_rdata       = rdata_reg;
	assign o_digit_index = idx_reg;
	assign o_irq         = irq_reg;

	// Helper for assertions: clocks spent in the key scan slot
	logic [11:0] ks_cnt_reg;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b || state_reg != ST_KEYSCAN) begin
			ks_cnt_reg <= 12'h000;
		end else begin
			ks_cnt_reg <= 12'(ks_cnt_reg + 12'h001);
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	a_keyscan_len: assert property ($past(state_reg) == ST_KEYSCAN && state_reg == ST_DISP && $stable(cycle_length_sel)
		|-> ks_cnt_reg == (cycle_length_sel ? CYC_LONG : CYC_SHORT)) // RULE_11
		else $error("key scan slot not one display cycle long");
	a_keyscan_flag: assert property (i_rd && i_addr == ADDR_MODE_A
		|=> o_rdata[MODE_A_KSF_BIT] == ($past(state_reg) == ST_KEYSCAN)) // RULE_17
		else $error("key scan flag does not match slot");
	a_keyscan_low: assert property (state_reg == ST_KEYSCAN |=> o_pin[KS_PORT_FIRST-1:0] == '0) // RULE_18
		else $error("low pins driven during key scan");
	a_keyscan_ports: assert property (state_reg == ST_KEYSCAN && $stable(i_port_latch)
		|=> o_pin[PIN_COUNT-1:KS_PORT_FIRST] == i_port_latch[PIN_COUNT-1:KS_PORT_FIRST]) // RULE_18
		else $error("port latches not shown during key scan");
	a_blank_start: assert property (state_reg == ST_STOP && digit_code != 4'h0
		|=> state_reg == ST_BLANK ##1 o_pin[1:0] == 2'b00) // RULE_09
		else $error("first cycle after start not blank");
	a_stop_on_zero: assert property (digit_code == 4'h0 |=> state_reg == ST_STOP) // RULE_04
		else $error("scan did not stop on zero count");
	a_digit_order: assert property (state_reg == ST_DISP && cycle_end && idx_reg < digit_code && digit_code != 4'h0
		|=> idx_reg == 4'($past(idx_reg) + 4'h1) && state_reg == ST_DISP) // RULE_19
		else $error("digits not scanned in ascending order");
	a_last_digit: assert property (state_reg == ST_DISP && cycle_end && idx_reg == digit_code
		|=> state_reg == ST_KEYSCAN) // RULE_19
		else $error("key scan slot not inserted after last digit");
	a_mask_upper: assert property (i_wr && i_addr == ADDR_MASK |=> mask_count_reg == {2'b00, $past(i_wdata[5:0])}) // RULE_08
		else $error("mask count upper bits not zero");
	a_irq_level: assert property (|(irq_stat_reg & irq_mask_reg) |=> o_irq) // RULE_17
		else $error("interrupt missing for unmasked event");

	// Interrupt drops once nothing unmasked is pending
	a_irq_low: assert property (!(|(irq_stat_reg & irq_mask_reg)) |=> !o_irq)
		else $error("interrupt high with nothing pending");
	// Read data stand only in the cycle after a read strobe
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data present without a read");
	// Writing a one clears the status bit when no event arrives with it
	a_irq_clear: assert property (i_wr && i_addr == ADDR_IRQ_STAT && i_wdata[IRQ_KS_BIT] && !irq_set[IRQ_KS_BIT]
		|=> !irq_stat_reg[IRQ_KS_BIT])
		else $error("status bit not cleared by write of one");
	// Event set beats a clearing write in the same cycle
	a_irq_set_wins: assert property (irq_set[IRQ_KS_BIT] |=> irq_stat_reg[IRQ_KS_BIT])
		else $error("key scan event lost");
	// Stopped display hands every pin to the port latches
	a_stop_ports: assert property (state_reg == ST_STOP && $stable(i_port_latch) |=> o_pin == i_port_latch) // RULE_04
		else $error("port latches not shown while stopped");
	// Flag reads zero while digits are being scanned
	a_flag_display: assert property (state_reg == ST_DISP && i_rd && i_addr == ADDR_MODE_A // RULE_17
		|=> !o_rdata[MODE_A_KSF_BIT])
		else $error("key scan flag set during display timing");

	c_keyscan_seen: cover property (state_reg == ST_DISP ##1 state_reg == ST_KEYSCAN);
	c_blank_seen: cover property (state_reg == ST_BLANK ##1 state_reg == ST_DISP);
	c_long_cycle: cover property (cycle_length_sel && state_reg == ST_DISP && cycle_end);
	c_irq_seen: cover property ($rose(o_irq));
	c_layout_two: cover property (layout_mode_sel && state_reg == ST_DISP && cycle_end);

endmodule : vst_scan_ctrl

// ### vst_panel_model.sv
// Panel side model: supplies segment patterns and checks the segment lines against the lit digit
`timescale 1ns/1ps
module vst_panel_model (
	input  wire logic                         i_core_clk,
	input  wire logic [vst_pkg::PIN_COUNT-1:0] i_pin,
	input  wire logic [3:0]                   i_digit_index,
	input  wire logic                         i_active,
	input  wire logic [5:0]                   i_seg_cnt,
	output logic [vst_pkg::SEG_IN_W-1:0]      o_seg_data,
	output logic [15:0]                       o_errs
);
	import vst_pkg::*;

	logic [39:0] msk;
	logic [39:0] exp_seg;

	initial o_errs = 16'h0000;

	// Pattern flips per digit so a wrong digit shows on the segment lines
	assign o_seg_data = i_digit_index[0] ? 40'haa_aaaa_aaaa : 40'h55_5555_5555;

	// Two digits only; outside a lit pulse the segments must be blanked too
	always @(posedge i_core_clk) begin
		if (i_active) begin
			msk = (40'h1 << i_seg_cnt) - 40'h1;
			exp_seg = (i_pin[1:0] == 2'b01) ? (40'h55_5555_5555 & msk) : 40'h0;
			exp_seg = (i_pin[1:0] == 2'b10) ? (40'haa_aaaa_aaaa & msk) : exp_seg;
			if (i_pin[1:0] === 2'b11 || (i_pin[41:2] & msk) !== exp_seg) begin
				o_errs <= o_errs + 16'h0001;
			end
		end
	end
endmodule : vst_panel_model

// ### vfd_scan_timing_control_tb.sv
// Self-checking bench for the display scan timing controller
`timescale 1ns/1ps
module vfd_scan_timing_control_tb;
	import vst_pkg::*;

	typedef struct {logic [15:0] a; logic [7:0] d; logic w; logic [7:0] e;} vst_row_t;
	// Ports 9 and up high so segment and port pins differ
	localparam logic [PIN_COUNT-1:0] LATCH = 53'h1f_ffff_ffff_fe00;

	logic                  i_core_clk = 1'b0;
	logic                  i_rst_b    = 1'b0;
	logic [15:0]           i_addr     = 16'h0000;
	logic [7:0]            i_wdata    = 8'h00;
	logic                  i_wr       = 1'b0;
	logic                  i_rd       = 1'b0;
	logic [7:0]            o_rdata;
	logic [SEG_IN_W-1:0]   seg_data;
	logic [PIN_COUNT-1:0]  o_pin;
	logic [3:0]            o_digit_index;
	logic                  o_irq;
	logic                  active     = 1'b0;
	logic [5:0]            seg_cnt    = 6'h09;
	logic [15:0]           model_errs;
	logic [7:0]            rd_val;
	int                    err_total  = 0;
	int                    num_checks = 0;
	int                    cyc        = 0;
	int                    n;
	int                    t0;
	vst_row_t              rows [8];

	vst_scan_ctrl i_vst_scan_ctrl (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_seg_data(seg_data),
		.i_port_latch(LATCH), .o_pin(o_pin), .o_digit_index(o_digit_index), .o_irq(o_irq));

	vst_panel_model i_vst_panel_model (.i_core_clk(i_core_clk), .i_pin(o_pin), .i_digit_index(o_digit_index),
		.i_active(active), .i_seg_cnt(seg_cnt), .o_seg_data(seg_data), .o_errs(model_errs));

	// 40 MHz clock
	always #12.5 i_core_clk = ~i_core_clk;

	// Hang guard, well above the roughly 48k cycles the run needs
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			results();
		end
	end

	task chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task bus_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : bus_wr

	// Read data stand only in the cycle after the strobe
	task bus_rd(input logic [15:0] a);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		rd_val = o_rdata;
	endtask : bus_rd

	// Negative pin number waits on the interrupt line
	task wait_hi(input int p, output int k);
		k = 0;
		#1;
		while ((p < 0 ? o_irq : o_pin[p]) !== 1'b1 && k < 6000) begin
			@(posedge i_core_clk);
			#1;
			k++;
		end
		if (k >= 6000) chk(1'b0, 1'b1);
	endtask : wait_hi

	function automatic int exp_w(input logic l, input logic [2:0] c);
		int len;
		int k;
		len = l ? 2048 : 1024;
		k = (c == 3'h0) ? 1 : 2 * int'(c);
		return len - 2 * (len * k / 32);
	endfunction : exp_w

	// Restart from stop, then watch blank, two digits and the key scan slot
	task measure(input logic [7:0] sv);
		int l;
		int b;
		int c0;
		int c1;
		int f0;
		int f1;
		l = sv[0] ? 2048 : 1024;
		b = 0;
		c0 = 0;
		c1 = 0;
		f0 = 0;
		f1 = 0;
		active <= 1'b0;
		bus_wr(ADDR_SCAN, 8'h00);
		bus_wr(ADDR_SCAN, sv);
		for (int i = 0; i < 4 * l; i++) begin
			@(posedge i_core_clk);
			#1;
			if (i == 2) active = 1'b1;
			if (i >= 2 && i < l && o_pin[10:0] !== 11'h000) b++;
			if (o_pin[0] === 1'b1) c0++;
			if (o_pin[1] === 1'b1) c1++;
			if (o_pin[0] === 1'b1 && f0 == 0) f0 = i;
			if (o_pin[1] === 1'b1 && f1 == 0) f1 = i;
		end
		chk(b, 0);
		chk(c0, exp_w(sv[0], sv[3:1]));
		chk(c1, exp_w(sv[0], sv[3:1]));
		chk(f0 < f1, 1'b1);
	endtask : measure

	task results;
		$display("Checks %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	initial begin
		rows[0] = '{ADDR_MODE_A, 8'h00, 1'b0, RST_MODE_A};
		rows[1] = '{ADDR_SCAN, 8'h00, 1'b0, RST_SCAN};
		rows[2] = '{ADDR_MASK, 8'h00, 1'b0, RST_MASK};
		rows[3] = '{ADDR_MASK, 8'h27, 1'b1, 8'h27};
		rows[4] = '{ADDR_MASK, 8'he7, 1'b1, 8'h27};
		rows[5] = '{ADDR_MODE_A, 8'h9f, 1'b1, 8'h1f};
		rows[6] = '{16'h1234, 8'h5a, 1'b1, 8'h00};
		rows[7] = '{ADDR_IRQ_MASK, 8'h03, 1'b1, 8'h03};
		repeat (5) @(posedge i_core_clk);
		#1;
		chk(o_pin, 53'h0);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk(o_pin, LATCH);
		chk(o_irq, 1'b0);
		// Register table
		foreach (rows[i]) begin
			if (rows[i].w) bus_wr(rows[i].a, rows[i].d);
			bus_rd(rows[i].a);
			chk(rd_val, rows[i].e);
		end
		bus_wr(ADDR_MODE_A, 8'h00);
		bus_wr(ADDR_IRQ_MASK, 8'h00);
		// Long cycle first, then every cut code on the short cycle
		for (int i = 0; i < 9; i++) measure(i == 0 ? 8'h11 : {4'h1, 3'(i - 1), 1'b0});
		// Key scan slot and interrupt
		bus_wr(ADDR_IRQ_MASK, 8'h01);
		bus_wr(ADDR_IRQ_STAT, 8'h03);
		repeat (2) @(posedge i_core_clk);
		wait_hi(-1, n);
		t0 = cyc;
		chk(o_pin[12:0], 13'h0);
		chk(o_pin[52:13], LATCH[52:13]);
		bus_rd(ADDR_MODE_A);
		chk(rd_val[7], 1'b1);
		wait_hi(0, n);
		chk((cyc - t0) > 1467 && (cyc - t0) < 1477, 1'b1);
		bus_rd(ADDR_MODE_A);
		chk(rd_val[7], 1'b0);
		bus_wr(ADDR_IRQ_MASK, 8'h00);
		repeat (2) @(posedge i_core_clk);
		#1;
		chk(o_irq, 1'b0);
		bus_wr(ADDR_IRQ_MASK, 8'h01);
		repeat (2) @(posedge i_core_clk);
		#1;
		chk(o_irq, 1'b1);
		bus_wr(ADDR_IRQ_STAT, 8'h01);
		repeat (2) @(posedge i_core_clk);
		#1;
		chk(o_irq, 1'b0);
		// Stop shows the port latches on every pin
		active <= 1'b0;
		bus_wr(ADDR_SCAN, 8'h00);
		repeat (3) @(posedge i_core_clk);
		#1;
		chk(o_pin, LATCH);
		// Layout two: fewer segment pins, the rest fall back to ports
		bus_wr(ADDR_MODE_A, 8'h20);
		seg_cnt <= 6'h07;
		bus_wr(ADDR_SCAN, 8'h10);
		repeat (4) @(posedge i_core_clk);
		active <= 1'b1;
		wait_hi(0, n);
		chk(o_pin[10:9], 2'b11);
		chk(o_pin[8:2], 7'h55);
		chk(o_pin[1], 1'b0);
		// Sixteen digits with forty segments: digits keep their pins
		active <= 1'b0;
		bus_wr(ADDR_SCAN, 8'h00);
		bus_wr(ADDR_MODE_A, 8'h1f);
		bus_wr(ADDR_SCAN, 8'hf0);
		wait_hi(1, n);
		chk(o_pin[52], 1'b0);
		chk(o_pin[0], 1'b0);
		chk(model_errs, 16'h0000);
		results();
	end
endmodule : vfd_scan_timing_control_tb
